// File: supply_lockout_pkg.sv
// supply lockout sequencer: shared constants and types
// assumes a 10 MHz internal sampling clock
package supply_lockout_pkg;

	// ------------------------------------------------------------
	// clock and delays
	// ------------------------------------------------------------
	localparam int CLK_FREQ_HZ                = 10000000;
	localparam int POWER_ON_RELEASE_TIME_US   = 64;
	localparam int LOCKOUT_DISABLE_DELAY_US   = 64;
	localparam int LOCKOUT_ENABLE_TIME_US     = 64;
	localparam int POWER_ON_RELEASE_CYCLES    = POWER_ON_RELEASE_TIME_US * (CLK_FREQ_HZ / 1000000);
	localparam int LOCKOUT_DISABLE_CYCLES     = LOCKOUT_DISABLE_DELAY_US * (CLK_FREQ_HZ / 1000000);
	localparam int LOCKOUT_ENABLE_CYCLES      = LOCKOUT_ENABLE_TIME_US * (CLK_FREQ_HZ / 1000000);
	localparam int TIMER_WIDTH                = 12;

	// ------------------------------------------------------------
	// quiescent levels in millivolts at a 5 V supply
	// ------------------------------------------------------------
	localparam logic [12:0] BIDIR_QUIESCENT_MV        = 13'h09C4;
	localparam logic [12:0] UNIDIRECTIONAL_QUIESCENT_MV = 13'h01F4;

	// ------------------------------------------------------------
	// output stage modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_HIGH_Z,
		MODE_NORMAL,
		MODE_CLAMP_GND
	} output_mode_t;

endpackage : supply_lockout_pkg

// File: delay_timer.sv
// delay_timer: restartable up-counter that flags a terminal count
// assumes reset and run are synchronous to the clock
`timescale 1ns/10ps
module delay_timer #(
	parameter int WIDTH    = 12,
	parameter int TERMINAL = 640
) (
	input  wire logic i_ref_clk,
	input  wire logic i_reset,
	input  wire logic i_run,
	output logic      o_done
);
	logic [WIDTH-1:0] count;

	// counter holds at terminal; dropping run clears it
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || !i_run) begin
			count <= '0;
		end else if (count != WIDTH'(TERMINAL)) begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset || !i_run) begin
			o_done <= 1'b0;
		end else begin
			o_done <= (count >= WIDTH'(TERMINAL - 1));
		end
	end
endmodule : delay_timer

// File: supply_lockout_output_sequencer.sv
// supply_lockout_output_sequencer: output stage mode from supply comparators
// assumes comparator flags are synchronous; i_reset is the power-on reset release
//
// Notes on behaviour
// - output is high impedance while supply ramps up from off
// - crossing upper power-on threshold starts the power-on release counter
// - supply already above upper lockout: midpoint after lockout-disable delay
// - below upper lockout: stay high impedance until reached, then delay
// - falling below lower lockout starts the lockout-enable counter
// - still below lower lockout at expiry: enter lockout, clamp near ground
// - recovery above lower lockout before expiry abandons lockout entry
// - in lockout, above upper lockout: leave after disable delay
// - power-down expiry above lower power-on threshold enters clamped lockout
// - below lower power-on threshold: clamp released into high impedance
// - below lower power-on before expiry: straight from normal to high impedance
// - unidirectional and bidirectional variants share the same sequencing
// - leave power-on high impedance only after release time and upper lockout
// - unidirectional quiescent level is 0.5 V at 5 V supply
`timescale 1ns/10ps
module supply_lockout_output_sequencer
	import supply_lockout_pkg::*;
#(
	parameter int  POR_RELEASE_CYCLES = POWER_ON_RELEASE_CYCLES,
	parameter int  DISABLE_CYCLES     = LOCKOUT_DISABLE_CYCLES,
	parameter int  ENABLE_CYCLES      = LOCKOUT_ENABLE_CYCLES,
	parameter bit  UNIDIRECTIONAL     = 1'b0
) (
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_reset,
	input  wire logic                       i_above_upper_power_on_threshold,
	input  wire logic                       i_above_lower_power_on_threshold,
	input  wire logic                       i_above_upper_lockout_threshold,
	input  wire logic                       i_above_lower_lockout_threshold,
	output supply_lockout_pkg::output_mode_t o_output_mode,
	output logic                            o_output_enable_n,
	output logic                            o_clamp_to_ground,
	output logic [12:0]                     o_quiescent_level_mv
);
	import supply_lockout_pkg::*;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF,
		ST_POR_WAIT,
		ST_DISABLE_WAIT,
		ST_NORMAL,
		ST_ENABLE_WAIT,
		ST_LOCKOUT,
		ST_RELEASE_WAIT
	} seq_state_t;

	seq_state_t   state;
	seq_state_t   next_state;
	output_mode_t next_mode;
	logic         por_run;
	logic         por_done;
	logic         disable_run;
	logic         disable_done;
	logic         enable_run;
	logic         enable_done;

	// ------------------------------------------------------------
	// delay counters
	// ------------------------------------------------------------
	// power-on release keeps counting once started, so it can expire
	// while the supply still waits for the upper lockout threshold
	assign por_run     = (state != ST_OFF) && i_above_lower_power_on_threshold;
	assign disable_run = (state == ST_DISABLE_WAIT) || (state == ST_RELEASE_WAIT);
	assign enable_run  = (state == ST_ENABLE_WAIT);

	delay_timer #(.WIDTH(TIMER_WIDTH), .TERMINAL(POR_RELEASE_CYCLES)) u_por_timer (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.i_run     (por_run),
		.o_done    (por_done)
	);

	delay_timer #(.WIDTH(TIMER_WIDTH), .TERMINAL(DISABLE_CYCLES)) u_disable_timer (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.i_run     (disable_run),
		.o_done    (disable_done)
	);

	delay_timer #(.WIDTH(TIMER_WIDTH), .TERMINAL(ENABLE_CYCLES)) u_enable_timer (
		.i_ref_clk (i_ref_clk),
		.i_reset   (i_reset),
		.i_run     (enable_run),
		.o_done    (enable_done)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (i_above_upper_power_on_threshold) begin
					next_state = ST_POR_WAIT;
				end
			end
			ST_POR_WAIT: begin
				// high impedance until both release time and lockout level
				if (!i_above_lower_power_on_threshold) begin
					next_state = ST_OFF;
				end else if (por_done && i_above_upper_lockout_threshold) begin
					next_state = ST_DISABLE_WAIT;
				end
			end
			ST_DISABLE_WAIT: begin
				if (!i_above_lower_power_on_threshold) begin
					next_state = ST_OFF;
				end else if (!i_above_upper_lockout_threshold) begin
					next_state = ST_POR_WAIT;
				end else if (disable_done) begin
					next_state = ST_NORMAL;
				end
			end
			ST_NORMAL: begin
				if (!i_above_lower_power_on_threshold) begin
					next_state = ST_OFF;
				end else if (!i_above_lower_lockout_threshold) begin
					next_state = ST_ENABLE_WAIT;
				end
			end
			ST_ENABLE_WAIT: begin
				if (!i_above_lower_power_on_threshold) begin
					next_state = ST_OFF;
				end else if (i_above_lower_lockout_threshold) begin
					next_state = ST_NORMAL;
				end else if (enable_done) begin
					next_state = ST_LOCKOUT;
				end
			end
			ST_LOCKOUT: begin
				if (!i_above_lower_power_on_threshold) begin
					next_state = ST_OFF;
				end else if (i_above_upper_lockout_threshold) begin
					next_state = ST_RELEASE_WAIT;
				end
			end
			ST_RELEASE_WAIT: begin
				if (!i_above_lower_power_on_threshold) begin
					next_state = ST_OFF;
				end else if (!i_above_upper_lockout_threshold) begin
					next_state = ST_LOCKOUT;
				end else if (disable_done) begin
					next_state = ST_NORMAL;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// output stage mode
	// ------------------------------------------------------------
	always_comb begin
		case (next_state)
			ST_NORMAL:       next_mode = MODE_NORMAL;
			ST_ENABLE_WAIT:  next_mode = MODE_NORMAL;
			ST_LOCKOUT:      next_mode = MODE_CLAMP_GND;
			ST_RELEASE_WAIT: next_mode = MODE_CLAMP_GND;
			default:         next_mode = MODE_HIGH_Z;
		endcase
	end

	// registered so the pin modes change only on clock edges
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_output_mode     <= MODE_HIGH_Z;
			o_output_enable_n <= 1'b1;
			o_clamp_to_ground <= 1'b0;
		end else begin
			o_output_mode     <= next_mode;
			o_output_enable_n <= (next_mode == MODE_HIGH_Z);
			o_clamp_to_ground <= (next_mode == MODE_CLAMP_GND);
		end
	end

	// variant only changes the quiescent level, never the sequencing
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_quiescent_level_mv <= 13'h0000;
		end else if (UNIDIRECTIONAL) begin
			o_quiescent_level_mv <= UNIDIRECTIONAL_QUIESCENT_MV;
		end else begin
			o_quiescent_level_mv <= BIDIR_QUIESCENT_MV;
		end
	end
endmodule : supply_lockout_output_sequencer

// File: supply_lockout_sva.sv
// supply_lockout_sva: port timing checks for the lockout sequencer
// assumes it is bound to the sequencer; one clock domain
`timescale 1ns/10ps
module supply_lockout_sva
	import supply_lockout_pkg::*;
#(
	parameter int DISABLE_CYCLES = 4,
	parameter int ENABLE_CYCLES  = 4,
	parameter bit UNIDIRECTIONAL = 1'b0
) (
	input wire logic        i_ref_clk,
	input wire logic        i_reset,
	input wire logic        i_above_upper_power_on_threshold,
	input wire logic        i_above_lower_power_on_threshold,
	input wire logic        i_above_upper_lockout_threshold,
	input wire logic        i_above_lower_lockout_threshold,
	input output_mode_t     o_output_mode,
	input wire logic        o_output_enable_n,
	input wire logic        o_clamp_to_ground,
	input wire logic [12:0] o_quiescent_level_mv
);
	wire          lp = i_above_lower_power_on_threshold;
	wire          ul = i_above_upper_lockout_threshold;
	wire          ll = i_above_lower_lockout_threshold;
	output_mode_t m;
	int           ul_run;
	int           ll_run;
	assign m = o_output_mode;
	// ------------------------------------------------------------
	// run lengths, so a delay cannot be skipped
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		ul_run <= (i_reset || !ul) ? 0 : ul_run + 1;
	end
	always_ff @(posedge i_ref_clk) begin
		ll_run <= (i_reset || ll) ? 0 : ll_run + 1;
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	// run counters stand in for the long delays, which no repetition could reach
	sequence low_expired;
		m == MODE_NORMAL && lp && !ll && ll_run == ENABLE_CYCLES + 1 ##1 lp && !ll;
	endsequence
	sequence high_expired;
		m == MODE_CLAMP_GND && lp && ul && ul_run == DISABLE_CYCLES + 1 ##1 lp && ul;
	endsequence
	a_enable_vs_mode: assert property (o_output_enable_n == (m == MODE_HIGH_Z))
		else $error("enable disagrees with mode");
	a_clamp_vs_mode: assert property (o_clamp_to_ground == (m == MODE_CLAMP_GND))
		else $error("clamp disagrees with mode");
	a_mode_legal: assert property (m inside {MODE_HIGH_Z, MODE_NORMAL, MODE_CLAMP_GND})
		else $error("illegal mode");
	a_level_fixed: assert property (!$past(i_reset) |-> o_quiescent_level_mv ==
		(UNIDIRECTIONAL ? UNIDIRECTIONAL_QUIESCENT_MV : BIDIR_QUIESCENT_MV))
		else $error("wrong quiescent level");
	a_release_delay: assert property ($past(m) == MODE_HIGH_Z && m == MODE_NORMAL
		|-> ul_run >= DISABLE_CYCLES) else $error("output enabled too early");
	a_entry_delay: assert property ($past(m) == MODE_NORMAL && m == MODE_CLAMP_GND
		|-> ll_run >= ENABLE_CYCLES) else $error("lockout entered too early");
	a_lockout_entry: assert property (low_expired |-> m == MODE_CLAMP_GND)
		else $error("lockout not entered");
	a_lockout_exit: assert property (high_expired |-> m == MODE_NORMAL)
		else $error("lockout not left");
	a_normal_holds: assert property ((m == MODE_NORMAL && ll && lp)[*2] |=> m == MODE_NORMAL)
		else $error("normal output lost");
	a_off_to_hz: assert property (!lp && m != MODE_HIGH_Z |=> m == MODE_HIGH_Z)
		else $error("no high impedance below power-on");
endmodule : supply_lockout_sva

// File: supply_lockout_output_sequencer_tb.sv
// supply_lockout_output_sequencer_tb: supply ramps and dips, mode changes checked
// assumes short delay parameters of 4 cycles
`timescale 1ns/10ps
module supply_lockout_output_sequencer_tb;
	import supply_lockout_pkg::*;
	logic         clk = 0, rst = 1, up = 0, lp = 0, ul = 0, ll = 0;
	logic         en_n, clamp;
	logic [12:0]  lvl, lvl_u;
	output_mode_t mode, mode_u, prev = MODE_HIGH_Z, want = MODE_HIGH_Z;
	output_mode_t exp_q[$];
	int           num_errors = 0, n_compared = 0;
	bit           live = 0;
	supply_lockout_output_sequencer #(.POR_RELEASE_CYCLES(4), .DISABLE_CYCLES(4),
		.ENABLE_CYCLES(4)) uut (.i_ref_clk(clk), .i_reset(rst),
		.i_above_upper_power_on_threshold(up), .i_above_lower_power_on_threshold(lp),
		.i_above_upper_lockout_threshold(ul), .i_above_lower_lockout_threshold(ll),
		.o_output_mode(mode), .o_output_enable_n(en_n), .o_clamp_to_ground(clamp),
		.o_quiescent_level_mv(lvl));
	// unidirectional variant on the same supply: only its quiescent level may differ
	supply_lockout_output_sequencer #(.POR_RELEASE_CYCLES(4), .DISABLE_CYCLES(4),
		.ENABLE_CYCLES(4), .UNIDIRECTIONAL(1'b1)) uut_uni (.i_ref_clk(clk), .i_reset(rst),
		.i_above_upper_power_on_threshold(up), .i_above_lower_power_on_threshold(lp),
		.i_above_upper_lockout_threshold(ul), .i_above_lower_lockout_threshold(ll),
		.o_output_mode(mode_u), .o_output_enable_n(), .o_clamp_to_ground(),
		.o_quiescent_level_mv(lvl_u));
	always #50 clk = ~clk;
	task automatic check(input logic [12:0] seen, input logic [12:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	// supply flags {up, lp, ul, ll}, held for n cycles
	task automatic go(input logic [3:0] v, input int n);
		{up, lp, ul, ll} = v;
		repeat (n) @(posedge clk);
		#1;
	endtask : go
	task automatic end_test(input string name);
		check(exp_q.size(), 0, "pending modes");
		$display("test %s ended", name);
	endtask : end_test
	// ------------------------------------------------------------
	// monitor: every mode change takes the oldest note
	// ------------------------------------------------------------
	always @(posedge clk) begin
		#2;
		if (live) begin
			check(lvl, BIDIR_QUIESCENT_MV, "level");
			if (mode !== prev) begin
				want = exp_q.size() ? exp_q.pop_front() : prev;
				check(mode, want, "mode");
				check(en_n, want == MODE_HIGH_Z, "enable_n");
				check(clamp, want == MODE_CLAMP_GND, "clamp");
			end
			check(mode_u, want, "unidirectional mode");
			check(lvl_u, UNIDIRECTIONAL_QUIESCENT_MV, "unidirectional level");
		end
		prev = mode;
	end
	initial begin
		#100000;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(37597));
		repeat (5) @(posedge clk);
		#1 rst = 0;
		// outputs leave their reset values only at the first edge after release
		@(posedge clk);
		#1 live = 1;
		go(4'b1101, 20 + $urandom % 10);
		exp_q.push_back(MODE_NORMAL);
		go(4'b1111, 15);
		end_test("slow power-up");
		go(4'b1100, 1 + $urandom % 3);
		go(4'b1101, 3);
		go(4'b1111, 5);
		end_test("short dip");
		exp_q.push_back(MODE_CLAMP_GND);
		go(4'b1100, 15);
		exp_q.push_back(MODE_NORMAL);
		go(4'b1111, 15);
		end_test("lockout round trip");
		go(4'b1100, 2);
		exp_q.push_back(MODE_HIGH_Z);
		go(4'b0000, 5);
		exp_q.push_back(MODE_NORMAL);
		go(4'b1111, 20);
		end_test("fast power-up");
		exp_q.push_back(MODE_CLAMP_GND);
		go(4'b1100, 15);
		exp_q.push_back(MODE_HIGH_Z);
		go(4'b0000, 5);
		end_test("power-down via lockout");
		tally_and_finish();
	end
endmodule : supply_lockout_output_sequencer_tb
bind supply_lockout_output_sequencer supply_lockout_sva #(.DISABLE_CYCLES(DISABLE_CYCLES),
	.ENABLE_CYCLES(ENABLE_CYCLES), .UNIDIRECTIONAL(UNIDIRECTIONAL)) chk (
	.i_ref_clk                        (i_ref_clk),
	.i_reset                          (i_reset),
	.i_above_upper_power_on_threshold (i_above_upper_power_on_threshold),
	.i_above_lower_power_on_threshold (i_above_lower_power_on_threshold),
	.i_above_upper_lockout_threshold  (i_above_upper_lockout_threshold),
	.i_above_lower_lockout_threshold  (i_above_lower_lockout_threshold),
	.o_output_mode                    (o_output_mode),
	.o_output_enable_n                (o_output_enable_n),
	.o_clamp_to_ground                (o_clamp_to_ground),
	.o_quiescent_level_mv             (o_quiescent_level_mv));
